// file: common/pes_pkg.sv
// package: register map, field positions and reset values for the per-phase event status bank
package pes_pkg;
  localparam int unsigned PES_ADDR_W = 16;
  localparam int unsigned PES_DATA_W = 32;
  localparam int unsigned PES_REG_W = 16;
  localparam int unsigned PES_NPH = 3;
  // printed offsets, all multiples of four, used as byte addresses
  localparam logic [15:0] PES_EVENT_OFS = 16'he600;
  localparam logic [15:0] PES_NOLOAD_OFS = 16'he608;
  // own additions: main status, enable and sag count
  localparam logic [15:0] PES_MAIN_STAT_OFS = 16'he610;
  localparam logic [15:0] PES_MAIN_EN_OFS = 16'he614;
  localparam logic [15:0] PES_SAG_CNT_OFS = 16'he618;
  // event register field positions
  localparam int unsigned PES_OC_POS = 3;
  localparam int unsigned PES_OV_POS = 9;
  localparam int unsigned PES_SAG_POS = 12;
  // no-load register field positions
  localparam int unsigned PES_NLT_POS = 0;
  localparam int unsigned PES_NLF_POS = 3;
  localparam int unsigned PES_NLA_POS = 6;
  // main status summary bits
  localparam int unsigned PES_SUM_NLT = 0;
  localparam int unsigned PES_SUM_NLF = 1;
  localparam int unsigned PES_SUM_NLA = 2;
  localparam int unsigned PES_SUM_SAG = 16;
  localparam int unsigned PES_SUM_OC = 17;
  localparam int unsigned PES_SUM_OV = 18;
  localparam logic [31:0] PES_MAIN_STAT_MASK = 32'h00070007;
  // reset values
  localparam logic [15:0] PES_EVENT_RST = 16'h0000;
  localparam logic [15:0] PES_NOLOAD_RST = 16'h0000;
  localparam logic [31:0] PES_MAIN_RST = 32'h00000000;
  localparam logic [15:0] PES_SAG_CNT_RST = 16'h0001;
  localparam logic [31:0] PES_ZERO = 32'h00000000;
endpackage

// file: common/pes_det_if.sv
// interface: per-phase detector levels and phase-qualified sag state
`timescale 1ns/1ps
interface pes_det_if;
  logic [2:0] sagBelow;
  logic [15:0] sagCount;
  logic [2:0] sagState;
  logic [2:0] sagToggle;
  modport filt (input sagBelow, input sagCount, output sagState, output sagToggle);
  modport top (output sagBelow, output sagCount, input sagState, input sagToggle);
endinterface

// file: logic/pes_sag_filter.sv
// module: per-phase sag state filter counting half line cycles
`timescale 1ns/1ps
module pes_sag_filter
  import pes_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic halfCycle,
  pes_det_if.filt det
);
  logic [2:0] state_ff;
  logic [2:0] toggle_ff;
  logic [CNT_W-1:0] run_ff [PES_NPH];

  // run length of samples disagreeing with the held state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PES_NPH; i++) run_ff[i] <= '0;
    end else begin
      for (int i = 0; i < PES_NPH; i++) begin
        if (det.sagBelow[i] == state_ff[i]) begin
          run_ff[i] <= '0;
        end else if (halfCycle) begin
          run_ff[i] <= CNT_W'(run_ff[i] + 1'b1);
        end
      end
    end
  end

  // state flips once the opposite level held for the programmed count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      toggle_ff <= '0;
    end else begin
      for (int i = 0; i < PES_NPH; i++) begin
        toggle_ff[i] <= 1'b0;
        if (det.sagBelow[i] != state_ff[i] && halfCycle && (run_ff[i] + 1'b1) >= det.sagCount[CNT_W-1:0]) begin
          state_ff[i] <= det.sagBelow[i];
          toggle_ff[i] <= 1'b1;
        end
      end
    end
  end

  assign det.sagState = state_ff;
  assign det.sagToggle = toggle_ff;
endmodule

// file: logic/per_phase_event_status.sv
// module: per-phase event source and no-load state registers behind an APB slave
// Function
// - reserved fields 2:0, 8:6 of events and 15:9 of no-load read zero
// - top bit 15 of the event register reads zero
// - bits 3..5 mark phase A..C overcurrent raising summary bit 17
// - bits 9..11 mark phase A..C overvoltage raising summary bit 18
// - bits 12..14 hold sag state, filtered over programmed half cycles
// - every sag state change raises summary bit 16
// - no-load bits 0..2 for total power, set with summary bit 0
// - no-load bits 3..5 for fundamental power, set with summary bit 1
// - no-load bits 6..8 for apparent power, set with summary bit 2
// - any enabled summary bit, overcurrent included, drives the interrupt request
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module per_phase_event_status
  import pes_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PES_ADDR_W-1:0] paddr,
  input wire logic [PES_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [PES_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] overcurrentIn,
  input wire logic [2:0] overvoltageIn,
  input wire logic [2:0] sagBelowIn,
  input wire logic halfCycleIn,
  input wire logic [2:0] totalNoloadIn,
  input wire logic [2:0] fundNoloadIn,
  input wire logic [2:0] apparentNoloadIn,
  output logic [15:0] phaseEventSource,
  output logic [15:0] phaseNoLoadState,
  output logic irqReq
);
  logic [15:0] event_ff;
  logic [15:0] noload_ff;
  logic [31:0] mainStat_ff;
  logic [31:0] mainEn_ff;
  logic [15:0] sagCnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;
  logic [31:0] nxt_mainStat;
  logic [15:0] nxt_event;
  logic [15:0] nxt_noload;
  logic [31:0] sumSet;
  logic [31:0] w1c;
  logic acc;
  logic wrEv;

  // detector inputs come from other logic on ref_clk, so no synchroniser
  pes_det_if det ();
  assign det.sagBelow = sagBelowIn;
  assign det.sagCount = sagCnt_ff;

  pes_sag_filter #(.CNT_W(16)) u_sag (
    .ref_clk(ref_clk),
    .rst(rst),
    .halfCycle(halfCycleIn),
    .det(det)
  );

  // byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // any-phase test used by every summary bit
  function automatic logic any_phase(input logic [2:0] v);
    return |v;
  endfunction

  // two-cycle access phase: answer registered at the first access edge, taken at the second
  assign acc = psel && penable && !pready_ff;
  assign wrEv = acc && pwrite;

  // phase source bits follow the detectors; reserved bits stay at zero
  always_comb begin
    nxt_event = PES_EVENT_RST;
    nxt_event[PES_OC_POS +: 3] = overcurrentIn;
    nxt_event[PES_OV_POS +: 3] = overvoltageIn;
    nxt_event[PES_SAG_POS +: 3] = det.sagState;
    nxt_noload = PES_NOLOAD_RST;
    nxt_noload[PES_NLT_POS +: 3] = totalNoloadIn;
    nxt_noload[PES_NLF_POS +: 3] = fundNoloadIn;
    nxt_noload[PES_NLA_POS +: 3] = apparentNoloadIn;
  end

  // registers written only by detection logic, never by the host
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_ff <= PES_EVENT_RST;
      noload_ff <= PES_NOLOAD_RST;
    end else begin
      event_ff <= nxt_event;
      noload_ff <= nxt_noload;
    end
  end

  // summary sources, same cycle as the phase bits are loaded
  always_comb begin
    sumSet = PES_ZERO;
    sumSet[PES_SUM_OC] = any_phase(overcurrentIn);
    sumSet[PES_SUM_OV] = any_phase(overvoltageIn);
    sumSet[PES_SUM_SAG] = any_phase(det.sagToggle);
    sumSet[PES_SUM_NLT] = any_phase(totalNoloadIn & ~noload_ff[PES_NLT_POS +: 3]);
    sumSet[PES_SUM_NLF] = any_phase(fundNoloadIn & ~noload_ff[PES_NLF_POS +: 3]);
    sumSet[PES_SUM_NLA] = any_phase(apparentNoloadIn & ~noload_ff[PES_NLA_POS +: 3]);
  end

  // write-one-to-clear on the main status word
  always_comb begin
    w1c = PES_ZERO;
    if (wrEv && paddr == PES_MAIN_STAT_OFS) begin
      w1c = lane_merge(PES_ZERO, pwdata, pstrb) & PES_MAIN_STAT_MASK;
    end
  end

  // set wins over a clear landing in the same cycle
  assign nxt_mainStat = (mainStat_ff & ~w1c) | sumSet;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mainStat_ff <= PES_MAIN_RST;
    end else begin
      mainStat_ff <= nxt_mainStat;
    end
  end

  // software-owned enable and sag count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mainEn_ff <= PES_MAIN_RST;
      sagCnt_ff <= PES_SAG_CNT_RST;
    end else if (wrEv) begin
      if (paddr == PES_MAIN_EN_OFS) begin
        mainEn_ff <= lane_merge(mainEn_ff, pwdata, pstrb) & PES_MAIN_STAT_MASK;
      end
      if (paddr == PES_SAG_CNT_OFS) begin
        sagCnt_ff <= 16'(lane_merge({16'h0000, sagCnt_ff}, pwdata, pstrb));
      end
    end
  end

  // interrupt: any enabled summary bit, overcurrent included
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_mainStat & mainEn_ff);
    end
  end

  // read mux and error answer; writes to read-only words are dropped silently
  always_comb begin
    nxt_prdata = PES_ZERO;
    nxt_slverr = 1'b0;
    case (paddr)
      PES_EVENT_OFS: nxt_prdata = {16'h0000, event_ff};
      PES_NOLOAD_OFS: nxt_prdata = {16'h0000, noload_ff};
      PES_MAIN_STAT_OFS: nxt_prdata = mainStat_ff;
      PES_MAIN_EN_OFS: nxt_prdata = mainEn_ff;
      PES_SAG_CNT_OFS: nxt_prdata = {16'h0000, sagCnt_ff};
      default: nxt_slverr = 1'b1;
    endcase
    if (pwrite) begin
      nxt_prdata = PES_ZERO;
    end
  end

  // apb answer registered: pready one cycle into the access phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= PES_ZERO;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && nxt_slverr;
      if (acc) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign phaseEventSource = event_ff;
  assign phaseNoLoadState = noload_ff;
  assign irqReq = irq_ff;
endmodule

// file: sim/pes_status_sva.sv
// checker: port-level properties of the per-phase event status bank
`timescale 1ns/1ps
module pes_status_sva
  import pes_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic halfCycleIn,
  input wire logic [2:0] overcurrentIn,
  input wire logic [2:0] overvoltageIn,
  input wire logic [2:0] totalNoloadIn,
  input wire logic [2:0] fundNoloadIn,
  input wire logic [2:0] apparentNoloadIn,
  input wire logic [15:0] phaseEventSource,
  input wire logic [15:0] phaseNoLoadState
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rsvd_evt_zero: assert property (phaseEventSource[2:0] == 3'h0 && phaseEventSource[8:6] == 3'h0)
    else $error("event reserved bits set");
  a_rsvd_nl_zero: assert property (phaseNoLoadState[15:9] == 7'h00)
    else $error("no-load reserved bits set");
  a_top_bit_zero: assert property (phaseEventSource[15] == 1'b0)
    else $error("event top bit set");
  a_oc_follows: assert property (phaseEventSource[5:3] == $past(overcurrentIn))
    else $error("overcurrent flags wrong");
  a_ov_follows: assert property (phaseEventSource[11:9] == $past(overvoltageIn))
    else $error("overvoltage flags wrong");
  a_noload_follows: assert property (phaseNoLoadState[8:0] ==
    {$past(apparentNoloadIn), $past(fundNoloadIn), $past(totalNoloadIn)}) else $error("no-load flags wrong");
  // sag state may only move shortly after a half-cycle pulse
  a_sag_on_pulse: assert property ($changed(phaseEventSource[14:12]) |->
    $past(halfCycleIn) || $past(halfCycleIn, 2) || $past(halfCycleIn, 3)) else $error("sag moved without pulse");
  a_ro_write_ok: assert property (psel && penable && pwrite && pready &&
    (paddr == PES_EVENT_OFS || paddr == PES_NOLOAD_OFS) |-> !pslverr) else $error("write to status refused");
endmodule
bind per_phase_event_status pes_status_sva i_pes_status_sva (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .halfCycleIn, .overcurrentIn, .overvoltageIn, .totalNoloadIn, .fundNoloadIn,
  .apparentNoloadIn, .phaseEventSource, .phaseNoLoadState);

// file: sim/tb_per_phase_event_status.sv
// testbench: apb-driven checks of the per-phase event status bank
`timescale 1ns/1ps
module tb_per_phase_event_status;
  import pes_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halfCycleIn = 1'b0, rerr;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, rdat, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] overcurrentIn = 3'h0, overvoltageIn = 3'h0, sagBelowIn = 3'h0;
  logic [2:0] totalNoloadIn = 3'h0, fundNoloadIn = 3'h0, apparentNoloadIn = 3'h0;
  logic pready, pslverr, irqReq;
  logic [15:0] phaseEventSource, phaseNoLoadState;
  int errTotal = 0, nCompared = 0;
  // free-running 250 mhz clock
  always #2 ref_clk = ~ref_clk;
  per_phase_event_status i_per_phase_event_status (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .overcurrentIn, .overvoltageIn, .sagBelowIn, .halfCycleIn,
    .totalNoloadIn, .fundNoloadIn, .apparentNoloadIn, .phaseEventSource, .phaseNoLoadState, .irqReq);
  task automatic stopTest;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits an edge first so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, PES_ZERO);
    chk(rdat, exp);
  endtask
  task automatic pulse;
    @(posedge ref_clk);
    halfCycleIn <= 1'b1;
    @(posedge ref_clk);
    halfCycleIn <= 1'b0;
  endtask
  // hang guard, far beyond the hundred-odd cycles the sequence needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    errTotal++;
    stopTest;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(PES_EVENT_OFS, PES_ZERO);
    rd(PES_NOLOAD_OFS, PES_ZERO);
    // one phase at a time, so a swapped phase index shows up
    for (int p = 0; p < 3; p++) begin
      overcurrentIn <= 3'h1 << p;
      overvoltageIn <= 3'h1 << p;
      totalNoloadIn <= 3'h1 << p;
      fundNoloadIn <= 3'h1 << p;
      apparentNoloadIn <= 3'h1 << p;
      apb(1'b1, PES_EVENT_OFS, 32'hffffffff);
      chk({31'h0, rerr}, PES_ZERO);
      rd(PES_EVENT_OFS, 32'h1 << (PES_OC_POS + p) | 32'h1 << (PES_OV_POS + p));
      chk({16'h0000, phaseEventSource}, 32'h1 << (PES_OC_POS + p) | 32'h1 << (PES_OV_POS + p));
      apb(1'b1, PES_NOLOAD_OFS, 32'hffffffff);
      rd(PES_NOLOAD_OFS, 32'h1 << p | 32'h1 << (PES_NLF_POS + p) | 32'h1 << (PES_NLA_POS + p));
      chk({16'h0000, phaseNoLoadState}, 32'h1 << p | 32'h1 << (PES_NLF_POS + p) | 32'h1 << (PES_NLA_POS + p));
      rd(PES_MAIN_STAT_OFS, 32'h00060007);
      {overcurrentIn, overvoltageIn, totalNoloadIn, fundNoloadIn, apparentNoloadIn} <= 15'h0;
      apb(1'b1, PES_MAIN_STAT_OFS, PES_MAIN_STAT_MASK);
    end
    apb(1'b1, PES_SAG_CNT_OFS, 32'h2);
    sagBelowIn <= 3'h2;
    pulse;
    rd(PES_EVENT_OFS, PES_ZERO);
    pulse;
    rd(PES_EVENT_OFS, 32'h1 << (PES_SAG_POS + 1));
    rd(PES_MAIN_STAT_OFS, 32'h1 << PES_SUM_SAG);
    apb(1'b1, PES_MAIN_STAT_OFS, PES_MAIN_STAT_MASK);
    sagBelowIn <= 3'h0;
    pulse;
    pulse;
    rd(PES_EVENT_OFS, PES_ZERO);
    rd(PES_MAIN_STAT_OFS, 32'h1 << PES_SUM_SAG);
    overcurrentIn <= 3'h4;
    apb(1'b1, PES_MAIN_EN_OFS, 32'h1 << PES_SUM_OC);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irqReq}, 32'h1);
    apb(1'b1, PES_MAIN_EN_OFS, PES_ZERO);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irqReq}, PES_ZERO);
    apb(1'b0, 16'he604, PES_ZERO);
    chk({31'h0, rerr}, 32'h1);
    stopTest;
  end
endmodule
